// ---- verilog/tone_gen_defines.svh ----
// Purpose: Constants for the stereo tone generator register file and datapath
// Assumes: Byte-wide register port, one access per cycle
// Notes: Offsets are the byte addresses of the control space
// Operation
// - Writing enable high starts the tone; hardware clears enable when duration ends.
// - Left volume code zero is +2 dB, each step 1 dB lower, to -61 dB.
// - Right volume code uses the same +2 dB to -61 dB mapping.
// - Link field 01 left uses right volume, 10 right uses left, else own.
// - No tone unless the DAC path runs the tone-capable processing mode.
// - Duration is a 24-bit sample count built from high, middle and low bytes.
// - Duration resets to high 0x00, middle 0x00, low 0xee.
// - Sine coefficient is 16 bits over two bytes, reset 0x10 and 0xd8.
// - Cosine coefficient is 16 bits over two bytes, reset 0x7e and 0xe3.
`ifndef TONE_GEN_DEFINES_SVH
`define TONE_GEN_DEFINES_SVH

`define ADDR_LEFT_CTL 8'h47
`define ADDR_RIGHT_CTL 8'h48
`define ADDR_LEN_HIGH 8'h49
`define ADDR_LEN_MID 8'h4a
`define ADDR_LEN_LOW 8'h4b
`define ADDR_SIN_HIGH 8'h4c
`define ADDR_SIN_LOW 8'h4d
`define ADDR_COS_HIGH 8'h4e
`define ADDR_COS_LOW 8'h4f

`define RST_LEFT_CTL 8'h00
`define RST_RIGHT_CTL 8'h00
`define RST_LEN_HIGH 8'h00
`define RST_LEN_MID 8'h00
`define RST_LEN_LOW 8'hee
`define RST_SIN_HIGH 8'h10
`define RST_SIN_LOW 8'hd8
`define RST_COS_HIGH 8'h7e
`define RST_COS_LOW 8'he3

`define BIT_ENABLE 7
`define VOL_MSB 5
`define LINK_MSB 7
`define LINK_LSB 6
`define LINK_L_FROM_R 2'h1
`define LINK_R_FROM_L 2'h2

// Oscillator seed amplitude is sine scaled down by this shift (half scale)
`define SEED_SHIFT 1
// Coefficients are Q15; the doubled cosine product is shifted by 14
`define OSC_SHIFT 14
`define GAIN_SHIFT 14

`endif

// ---- verilog/tone_gen_pkg.sv ----
// Purpose: Types shared by the tone generator modules
// Assumes: Nothing beyond the defines header
// Notes: Sample word carries left in the upper half
package tone_gen_pkg;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } tone_state_e;
   typedef logic signed [15:0] sample_t;
   typedef logic [31:0] pair_t;
endpackage : tone_gen_pkg

// ---- verilog/tone_stream_if.sv ----
// Purpose: Valid/ready carrier of stereo sample pairs between internal modules
// Assumes: Single clock domain
// Notes: Transfer happens when valid and ready are both high
interface tone_stream_if;
   logic valid;
   logic ready;
   tone_gen_pkg::pair_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : tone_stream_if

// ---- verilog/tone_skid_buf.sv ----
// Purpose: Two-entry buffer between the oscillator and the DAC path
// Assumes: Source holds nothing back; it only pushes when ready is high
// Notes: Head entry drives the outputs directly from flip-flops
module tone_skid_buf (
   input wire logic clk,
   input wire logic rst_n,
   tone_stream_if.snk in_s,
   output logic out_valid,
   output tone_gen_pkg::pair_t out_data,
   input wire logic out_ready
);
   tone_gen_pkg::pair_t entry_r [2];
   logic spare_v_r;
   logic push;
   logic pop;

   // Ready from a flop keeps the oscillator free of a combinational loop
   assign in_s.ready = !spare_v_r;
   assign push = in_s.valid && !spare_v_r;
   assign pop = out_valid && out_ready;
   assign out_data = entry_r[0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         spare_v_r <= 1'b0;
         entry_r[0] <= 32'h0;
         entry_r[1] <= 32'h0;
      end else if (!out_valid) begin
         if (push) begin
            entry_r[0] <= in_s.data;
            out_valid <= 1'b1;
         end
      end else if (!spare_v_r) begin
         if (pop && push) begin
            entry_r[0] <= in_s.data;
         end else if (pop) begin
            out_valid <= 1'b0;
         end else if (push) begin
            entry_r[1] <= in_s.data;
            spare_v_r <= 1'b1;
         end
      end else if (pop) begin
         entry_r[0] <= entry_r[1];
         spare_v_r <= 1'b0;
      end
   end

   hold_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("Buffered sample changed while stalled");
   spare_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
      spare_v_r && out_ready |=> !spare_v_r && out_valid)
      else $error("Spare entry not moved to head");
endmodule : tone_skid_buf

// ---- verilog/tone_gen.sv ----
// Purpose: Stereo sine tone generator feeding the DAC playback path
// Assumes: sample_tick is a one-cycle DAC word strobe on clk
// Notes: Left control read shows the live enable; gain steps use 6 dB = x2
`include "tone_gen_defines.svh"
module tone_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sample_tick,
   input wire logic tone_capable_dac_processing_mode,
   output logic tone_active,
   output logic tone_valid,
   output tone_gen_pkg::pair_t tone_data,
   input wire logic tone_ready
);
   logic [7:0] left_ctl_r;
   logic [7:0] right_ctl_r;
   logic [7:0] len_high_r;
   logic [7:0] len_mid_r;
   logic [7:0] len_low_r;
   logic [7:0] sin_high_r;
   logic [7:0] sin_low_r;
   logic [7:0] cos_high_r;
   logic [7:0] cos_low_r;
   tone_gen_pkg::tone_state_e state_r;
   logic [23:0] remain_r;
   logic pend_r;
   tone_gen_pkg::sample_t y_cur_r;
   tone_gen_pkg::sample_t y_prev_r;
   tone_gen_pkg::sample_t y_nxt;
   logic wr_left;
   logic start;
   logic fire;
   logic done;
   logic [5:0] vol_left;
   logic [5:0] vol_right;
   logic [1:0] link;

   tone_stream_if tone_s ();

   // Gain 10^((2-code)/20) as Q14 mantissa per 1 dB step, halved each 6 dB
   function automatic tone_gen_pkg::sample_t apply_gain(
      input tone_gen_pkg::sample_t s, input logic [5:0] code);
      logic [3:0] q;
      logic [2:0] r;
      logic [15:0] m;
      logic signed [31:0] p;
      q = 4'(code / 6'h6);
      r = 3'(code % 6'h6);
      unique case (r)
         3'h0: m = 16'h5092;
         3'h1: m = 16'h47cf;
         3'h2: m = 16'h4000;
         3'h3: m = 16'h390b;
         3'h4: m = 16'h32d6;
         default: m = 16'h2d4f;
      endcase
      p = 32'(s) * 32'($signed(m));
      p = (p >>> `GAIN_SHIFT) >>> q;
      return p[15:0];
   endfunction : apply_gain

   function automatic tone_gen_pkg::sample_t sat16(input logic signed [17:0] v);
      if (v > 18'sh07fff) begin
         return 16'sh7fff;
      end else if (v < -18'sh08000) begin
         return -16'sh8000;
      end
      return v[15:0];
   endfunction : sat16

   assign wr_left = reg_wr_en && reg_addr == `ADDR_LEFT_CTL;
   assign start = wr_left && reg_wdata[`BIT_ENABLE];
   assign link = right_ctl_r[`LINK_MSB:`LINK_LSB];
   // Volume source selection
   assign vol_left = link == `LINK_L_FROM_R ? right_ctl_r[`VOL_MSB:0]
                                            : left_ctl_r[`VOL_MSB:0];
   assign vol_right = link == `LINK_R_FROM_L ? left_ctl_r[`VOL_MSB:0]
                                             : right_ctl_r[`VOL_MSB:0];
   // Tone only advances in the tone-capable processing mode
   assign fire = state_r == tone_gen_pkg::ST_RUN && pend_r && tone_s.ready &&
                 remain_r != 24'h0 && tone_capable_dac_processing_mode;
   assign done = state_r == tone_gen_pkg::ST_RUN &&
                 (remain_r == 24'h0 || !tone_capable_dac_processing_mode);

   always_comb begin
      logic signed [31:0] prod;
      prod = 32'($signed({cos_high_r, cos_low_r})) * 32'(y_cur_r);
      y_nxt = sat16(18'(prod >>> `OSC_SHIFT) - 18'(y_prev_r));
   end

   assign tone_s.valid = fire;
   assign tone_s.data = {apply_gain(y_cur_r, vol_left),
                         apply_gain(y_cur_r, vol_right)};

   // Software write of the enable wins over the hardware clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         left_ctl_r <= `RST_LEFT_CTL;
         state_r <= tone_gen_pkg::ST_IDLE;
      end else if (wr_left) begin
         left_ctl_r <= reg_wdata;
         state_r <= start ? tone_gen_pkg::ST_RUN : tone_gen_pkg::ST_IDLE;
      end else if (done) begin
         left_ctl_r[`BIT_ENABLE] <= 1'b0;
         state_r <= tone_gen_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         right_ctl_r <= `RST_RIGHT_CTL;
         len_high_r <= `RST_LEN_HIGH;
         len_mid_r <= `RST_LEN_MID;
         len_low_r <= `RST_LEN_LOW;
         sin_high_r <= `RST_SIN_HIGH;
         sin_low_r <= `RST_SIN_LOW;
         cos_high_r <= `RST_COS_HIGH;
         cos_low_r <= `RST_COS_LOW;
      end else if (reg_wr_en) begin
         unique case (reg_addr)
            `ADDR_RIGHT_CTL: right_ctl_r <= reg_wdata;
            `ADDR_LEN_HIGH: len_high_r <= reg_wdata;
            `ADDR_LEN_MID: len_mid_r <= reg_wdata;
            `ADDR_LEN_LOW: len_low_r <= reg_wdata;
            `ADDR_SIN_HIGH: sin_high_r <= reg_wdata;
            `ADDR_SIN_LOW: sin_low_r <= reg_wdata;
            `ADDR_COS_HIGH: cos_high_r <= reg_wdata;
            `ADDR_COS_LOW: cos_low_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         unique case (reg_addr)
            `ADDR_LEFT_CTL: reg_rdata <= left_ctl_r;
            `ADDR_RIGHT_CTL: reg_rdata <= right_ctl_r;
            `ADDR_LEN_HIGH: reg_rdata <= len_high_r;
            `ADDR_LEN_MID: reg_rdata <= len_mid_r;
            `ADDR_LEN_LOW: reg_rdata <= len_low_r;
            `ADDR_SIN_HIGH: reg_rdata <= sin_high_r;
            `ADDR_SIN_LOW: reg_rdata <= sin_low_r;
            `ADDR_COS_HIGH: reg_rdata <= cos_high_r;
            `ADDR_COS_LOW: reg_rdata <= cos_low_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Remaining sample count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remain_r <= 24'h0;
      end else if (start) begin
         remain_r <= {len_high_r, len_mid_r, len_low_r};
      end else if (fire) begin
         remain_r <= remain_r - 24'h1;
      end
   end

   // A pending tick waits out a stall; further ticks in the same stall merge into it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (sample_tick) begin
         pend_r <= 1'b1;
      end else if (fire) begin
         pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         y_cur_r <= 16'sh0;
         y_prev_r <= 16'sh0;
      end else if (start) begin
         y_cur_r <= $signed({sin_high_r, sin_low_r}) >>> `SEED_SHIFT;
         y_prev_r <= 16'sh0;
      end else if (fire) begin
         y_cur_r <= y_nxt;
         y_prev_r <= y_cur_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tone_active <= 1'b0;
      end else begin
         tone_active <= start || (state_r == tone_gen_pkg::ST_RUN && !done);
      end
   end

   tone_skid_buf u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .in_s(tone_s),
      .out_valid(tone_valid),
      .out_data(tone_data),
      .out_ready(tone_ready)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence run_expired;
      state_r == tone_gen_pkg::ST_RUN && remain_r == 24'h0 && !wr_left;
   endsequence
   sequence tone_started;
      start ##1 state_r == tone_gen_pkg::ST_RUN;
   endsequence

   enable_clear_a: assert property (run_expired |=>
      !left_ctl_r[`BIT_ENABLE] && state_r == tone_gen_pkg::ST_IDLE)
      else $error("Enable not cleared at end of duration");
   start_load_a: assert property (start |=>
      left_ctl_r[`BIT_ENABLE] &&
      remain_r == {$past(len_high_r), $past(len_mid_r), $past(len_low_r)})
      else $error("Duration not loaded on start");
   start_seed_a: assert property (tone_started |-> y_prev_r == 16'sh0)
      else $error("Oscillator not seeded on start");
   mode_gate_a: assert property (!tone_capable_dac_processing_mode
      |-> !tone_s.valid ##1 !left_ctl_r[`BIT_ENABLE] || $past(start))
      else $error("Tone produced outside tone-capable mode");
   count_step_a: assert property (fire && !start |=>
      remain_r == $past(remain_r) - 24'h1)
      else $error("Sample count did not step by one");
   link_left_a: assert property (link == `LINK_L_FROM_R |->
      vol_left == right_ctl_r[`VOL_MSB:0] &&
      vol_right == right_ctl_r[`VOL_MSB:0])
      else $error("Left volume not taken from right");
   link_right_a: assert property (link == `LINK_R_FROM_L |->
      vol_right == left_ctl_r[`VOL_MSB:0] &&
      vol_left == left_ctl_r[`VOL_MSB:0])
      else $error("Right volume not taken from left");
   len_reset_a: assert property ($rose(rst_n) |->
      {len_high_r, len_mid_r, len_low_r} == 24'h0000ee)
      else $error("Duration reset value wrong");
   coef_reset_a: assert property ($rose(rst_n) |->
      {sin_high_r, sin_low_r} == 16'h10d8 &&
      {cos_high_r, cos_low_r} == 16'h7ee3)
      else $error("Coefficient reset value wrong");
endmodule : tone_gen

// ---- tb/tone_dac_model.sv ----
// Purpose: Stand-in for the DAC path that pulls tone sample pairs
// Assumes: One word strobe every 8 clocks; ready high on even phases only
// Notes: stall holds ready low so the two-entry buffer fills up
module tone_dac_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic clr,
   input wire logic tone_valid,
   input wire tone_gen_pkg::pair_t tone_data,
   output logic sample_tick,
   output logic tone_ready,
   output int n_taken,
   output tone_gen_pkg::pair_t first_pair
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] div = 3'h0;
   initial begin
      sample_tick = 1'b0;
      tone_ready = 1'b0;
      n_taken = 0;
      first_pair = '0;
   end
   always @(posedge clk) begin
      if (tone_valid === 1'b1 && tone_ready === 1'b1) begin
         if (n_taken == 0) first_pair <= tone_data;
         n_taken <= n_taken + 1;
      end
      if (clr) n_taken <= 0;
      div <= rst_n ? div + 3'h1 : 3'h0;
      // No strobe while reset holds, like a word clock not yet started
      sample_tick <= #1 rst_n && (div == 3'h7);
      tone_ready <= #1 !stall && !div[0];
   end
endmodule : tone_dac_model

// ---- tb/stereo_beep_tone_generator_tb.sv ----
// Purpose: Self-checking bench for the stereo tone generator
// Assumes: Tasks start and end 1 ns after a rising edge
// Notes: Gain is judged by ratios since the dB curve is approximate
module stereo_beep_tone_generator_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic mode = 1'b1, stall = 1'b0, clr = 1'b0;
   logic tick, active, valid, ready;
   tone_gen_pkg::pair_t data, first;
   int n_taken, n_fail = 0, compares = 0;
   logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10,
      8'hd8, 8'h7e, 8'he3};
   initial forever #5 clk = ~clk;
   tone_gen dut_u (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr_en),
      .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .sample_tick(tick),
      .tone_capable_dac_processing_mode(mode), .tone_active(active),
      .tone_valid(valid), .tone_data(data), .tone_ready(ready));
   tone_dac_model dac_u (.clk(clk), .rst_n(rst_n), .stall(stall),
      .clr(clr), .tone_valid(valid), .tone_data(data), .sample_tick(tick),
      .tone_ready(ready), .n_taken(n_taken), .first_pair(first));
   task automatic tally_and_finish();
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic reset_dut();
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
   endtask : reset_dut
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1 wr_en = 1'b0;
      // Idle edge keeps back-to-back strobes apart
      @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      rd_en = 1'b1;
      addr = a;
      @(posedge clk);
      #1 rd_en = 1'b0;
      v = rdata;
      @(posedge clk);
      #1;
   endtask : rd
   task automatic sc_registers();
      logic [7:0] v;
      for (int i = 0; i < 9; i++) begin
         rd(8'h47 + 8'(i), v);
         check("reset_value", v, rst_tab[i]);
      end
      for (int i = 1; i < 9; i++) wr(8'h47 + 8'(i), ~rst_tab[i]);
      wr(8'h47, 8'h3f);
      wr(8'h50, 8'hff);
      for (int i = 1; i < 9; i++) begin
         rd(8'h47 + 8'(i), v);
         check("rw_value", v, 8'(~rst_tab[i]));
      end
      rd(8'h47, v);
      check("left_ctl", v, 8'h3f);
      rd(8'h50, v);
      check("unmapped", v, 8'h00);
   endtask : sc_registers
   // Enables one tone, optionally stalling the sink, and waits for the
   // self clear of enable before counting what the DAC side received
   task automatic run_tone(input logic [23:0] len, input logic [7:0] rctl,
      input logic [5:0] lvol, input int hold);
      logic [7:0] v;
      int i;
      wr(8'h48, rctl);
      wr(8'h49, len[23:16]);
      wr(8'h4a, len[15:8]);
      wr(8'h4b, len[7:0]);
      clr = 1'b1;
      stall = (hold > 0);
      @(posedge clk);
      #1 clr = 1'b0;
      wr(8'h47, {2'b10, lvol});
      check("active", active, len != 24'h0 && mode);
      if (hold > 0) begin
         repeat (hold) @(posedge clk);
         #1 check("held_valid", valid, 1'b1);
         stall = 1'b0;
      end
      for (i = 0; i < 3000; i++) begin
         rd(8'h47, v);
         if (v[7] === 1'b0) break;
      end
      if (i == 3000) begin
         n_fail++;
         tally_and_finish();
      end
      repeat (60) @(posedge clk);
      #1 check("pairs", n_taken, mode ? 32'(len) : 32'h0);
      check("idle", active, 1'b0);
   endtask : run_tone
   task automatic sc_links();
      tone_gen_pkg::sample_t l, r;
      logic signed [17:0] d;
      for (int k = 0; k < 4; k++) begin
         run_tone(24'h3, {2'(k), 6'h06}, 6'h00, 0);
         l = first[31:16];
         r = first[15:0];
         d = 18'(l) - 18'(r) * 18'sd2;
         if (k == 1 || k == 2) check("link", 32'(l), 32'(r));
         else check("gain_6db", d >= -2 && d <= 2, 1'b1);
      end
   endtask : sc_links
   task automatic sc_lengths();
      run_tone(24'h8, 8'h00, 6'h00, 150);
      run_tone(24'h100, 8'h00, 6'h00, 0);
      run_tone(24'h0, 8'h00, 6'h00, 0);
   endtask : sc_lengths
   task automatic sc_mode_off();
      mode = 1'b0;
      run_tone(24'h4, 8'h00, 6'h00, 0);
      check("mode_off", n_taken, 0);
      mode = 1'b1;
   endtask : sc_mode_off
   initial begin
      reset_dut();
      sc_registers();
      reset_dut();
      sc_links();
      sc_lengths();
      sc_mode_off();
      tally_and_finish();
   end
endmodule : stereo_beep_tone_generator_tb
